/* logic/trace_ctl_pkg.sv */
// Package of constants and types for the trace and break control block
package trace_ctl_pkg;
	localparam int ADDR_W = 4;
	localparam int DATA_W = 32;
	localparam int TIME_W = 32;

	// Register offsets (word index on the plain register port)
	localparam logic [ADDR_W-1:0] REG_CONFIG    = 4'h0;
	localparam logic [ADDR_W-1:0] REG_CONTROL   = 4'h1;
	localparam logic [ADDR_W-1:0] REG_STATUS    = 4'h2;
	localparam logic [ADDR_W-1:0] REG_ALLOC     = 4'h3;
	localparam logic [ADDR_W-1:0] REG_ACTIVE    = 4'h4;
	localparam logic [ADDR_W-1:0] REG_LIMIT     = 4'h5;
	localparam logic [ADDR_W-1:0] REG_RESULT    = 4'h6;
	localparam logic [ADDR_W-1:0] REG_CLK_FREQ  = 4'h7;
	localparam logic [ADDR_W-1:0] REG_IBRK_EN   = 4'h8;

	// CONFIG fields
	localparam int CFG_TRACE_INT  = 0;
	localparam int CFG_GROUP_EN   = 1;
	localparam int CFG_ANALYZER   = 2;
	localparam int CFG_USEC_DISP  = 3;
	// CONTROL fields (write-only pulses)
	localparam int CTL_GO         = 0;
	localparam int CTL_HALT       = 1;
	localparam int CTL_MEASURE    = 2;
	// ALLOC fields
	localparam int AL_MODE_LSB    = 0;
	localparam int AL_START_LSB   = 2;
	localparam int AL_END_LSB     = 4;
	localparam int AL_CNT_SRC     = 6;
	localparam int AL_ED_START    = 7;
	localparam int AL_ED_END      = 8;
	localparam int AL_UNIT_LSB    = 9;
	localparam int AL_HALT_LIMIT  = 11;
	localparam int AL_REC_TIME    = 12;
	localparam int AL_BRK_SRC_LSB = 13;
	// ACTIVE fields: resource A, B, C, enable, disable
	localparam int ACT_A = 0;
	localparam int ACT_B = 1;
	localparam int ACT_C = 2;
	localparam int ACT_EN = 3;
	localparam int ACT_DIS = 4;
	localparam int NUM_ACT = 5;

	localparam int NUM_IBRK = 16;
	localparam logic [15:0] ALLOC_RST = 16'h0000;
	localparam logic [NUM_ACT-1:0] ACTIVE_RST = 5'h00;

	// Microsecond tick from the 20 MHz core clock
	localparam int CLK_HZ = 20_000_000;
	localparam int US_PER_TICK = 1;
	localparam int US_CYC = CLK_HZ / 1_000_000 * US_PER_TICK;
	// Frequency gate window in milliseconds
	localparam int GATE_MS = 1;
	localparam int GATE_CYC = CLK_HZ / 1000 * GATE_MS;

	typedef enum logic [1:0] {MODE_BRK_TRACE, MODE_COUNTER, MODE_TIMER} alloc_mode_t;
	typedef enum logic [1:0] {SRC_A, SRC_B, SRC_C} evt_src_t;
	typedef enum logic [1:0] {UNIT_TSTATE, UNIT_MCYCLE, UNIT_USEC} time_unit_t;
	typedef enum logic [1:0] {RUN_BREAK, RUN_RUNNING, RUN_PSEUDO} run_state_t;
endpackage

/* logic/perf_meter.sv */
// Timer and counter engine for the performance modes
`timescale 1ns/1ps
module perf_meter
	import trace_ctl_pkg::*;
#(
	parameter int W = TIME_W
) (
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic         run,
	input  wire alloc_mode_t  mode,
	input  wire logic         start_evt,
	input  wire logic         end_evt,
	input  wire logic         count_evt,
	input  wire logic         tick,
	input  wire logic [W-1:0] limit,
	input  wire logic         halt_en,
	output logic [W-1:0]      result,
	output logic              done,
	output logic              over
);
	logic [W-1:0] acc_r;
	logic         busy_r;
	logic         is_tmr;
	logic         is_cnt;
	logic         inc;
	logic [W-1:0] acc_nxt;

	assign is_tmr = (mode == MODE_TIMER);
	assign is_cnt = (mode == MODE_COUNTER);
	assign inc    = busy_r & ((is_tmr & tick) | (is_cnt & count_evt));
	// A tick landing with the end event still belongs to the span, else results run one short
	assign acc_nxt = acc_r + {{(W-1){1'b0}}, inc};

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			acc_r  <= '0;
			busy_r <= 1'b0;
			result <= '0;
			done   <= 1'b0;
			over   <= 1'b0;
		end else begin
			done <= 1'b0;
			over <= 1'b0;
			if (!run || !(is_tmr || is_cnt)) begin
				busy_r <= 1'b0;
			end else if (!busy_r && start_evt) begin
				busy_r <= 1'b1;
				acc_r  <= '0;
			end else if (busy_r && end_evt) begin
				busy_r <= 1'b0;
				result <= acc_nxt;
				done   <= 1'b1;
				over   <= is_tmr & halt_en & (acc_nxt > limit);
			end else if (inc) begin
				acc_r <= acc_nxt;
			end
		end
	end
endmodule

/* logic/trace_break_ctl.sv */
// Trace, trigger and break control of the emulator for the target bus
// Functional notes
// - Ignore mode drops internal and refresh cycles
// - Traced mode keeps them if otherwise qualified
// - Group break starts and stops units together; a unit in pseudo-halt ignores the group start
// - Group start/stop passes down a daisy chain; chain_out sends only this unit's own start/stop, and chain_in is not forwarded
// - Emulator mode halts CPU on break or halt
// - Analyzer mode keeps CPU running, pseudo-halt
// - Analyzer to emulator when stopped halts CPU
// - Analyzer run attaches trace, break detaches
// - No register view in analyzer when stopped
// - Measure target clock, convert T states to us
// - Resource acts only once activated
// - Default gives trace, trigger, breakpoint, 16 ibreaks
// - Three modes, break/trace first, mode retained
// - Break/trace mode uses B for instruction breaks
// - Timer measures from start to end event
// - Enable/disable may gate timer start or end
// - Timer writes each time into trace memory
// - Timer may halt when time exceeds limit
// - Timer unit: T states, machine cycles, us
// - Counter counts A or B occurrences
// - Enable starts and disable ends counting
// - Enable/disable windows A or B
//
// The placing of the registers and the plain strobed port were left to the implementer.
`timescale 1ns/1ps
module trace_break_ctl
	import trace_ctl_pkg::*;
#(
	parameter int GATE_CYCLES = GATE_CYC
) (
	input  wire logic              core_clk,
	input  wire logic              rst_n,
	input  wire logic [ADDR_W-1:0] reg_addr,
	input  wire logic [DATA_W-1:0] reg_wdata,
	input  wire logic              reg_wr,
	input  wire logic              reg_rd,
	output logic      [DATA_W-1:0] reg_rdata,
	input  wire logic              bus_cycle,
	input  wire logic              bus_internal,
	input  wire logic              bus_refresh,
	input  wire logic              bus_fetch,
	input  wire logic              bus_as,
	input  wire logic              tgt_clk_tick,
	input  wire logic              match_a,
	input  wire logic              match_b,
	input  wire logic              match_c,
	input  wire logic              match_en,
	input  wire logic              match_dis,
	input  wire logic [NUM_IBRK-1:0] ibrk_hit,
	input  wire logic              viol_break,
	input  wire logic              chain_in,
	output logic                   chain_out,
	output logic                   cpu_halt,
	output logic                   trace_attach,
	output logic                   trace_wr,
	output logic                   trace_trigger,
	output logic                   time_wr,
	output logic      [TIME_W-1:0] time_data,
	output logic                   regs_visible
);
	logic rs1_r, rs_r;
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rs1_r <= 1'b0;
			rs_r  <= 1'b0;
		end else begin
			rs1_r <= 1'b1;
			rs_r  <= rs1_r;
		end
	end

	logic [3:0]          cfg_r;
	logic [15:0]         alloc_r;
	logic [NUM_ACT-1:0]  active_r;
	logic [TIME_W-1:0]   limit_r;
	logic [NUM_IBRK-1:0] ibrk_en_r;
	logic [TIME_W-1:0]   freq_r;
	run_state_t          run_r;
	logic                chain_in_r;

	wire wr_cfg   = reg_wr & (reg_addr == REG_CONFIG);
	wire wr_ctl   = reg_wr & (reg_addr == REG_CONTROL);
	wire wr_alloc = reg_wr & (reg_addr == REG_ALLOC);
	wire wr_act   = reg_wr & (reg_addr == REG_ACTIVE);
	wire wr_lim   = reg_wr & (reg_addr == REG_LIMIT);
	wire wr_ibrk  = reg_wr & (reg_addr == REG_IBRK_EN);
	wire go_req   = wr_ctl & reg_wdata[CTL_GO];
	wire halt_req = wr_ctl & reg_wdata[CTL_HALT];
	wire meas_req = wr_ctl & reg_wdata[CTL_MEASURE];

	wire analyzer = cfg_r[CFG_ANALYZER];
	wire group_en = cfg_r[CFG_GROUP_EN];
	alloc_mode_t mode;
	evt_src_t    start_src, end_src;
	time_unit_t  unit;
	evt_src_t    brk_src;
	assign mode      = alloc_mode_t'(alloc_r[AL_MODE_LSB +: 2]);
	assign start_src = evt_src_t'(alloc_r[AL_START_LSB +: 2]);
	assign end_src   = evt_src_t'(alloc_r[AL_END_LSB +: 2]);
	assign unit      = time_unit_t'(alloc_r[AL_UNIT_LSB +: 2]);
	assign brk_src   = evt_src_t'(alloc_r[AL_BRK_SRC_LSB +: 2]);

	// Unused encodings fall back to break/trace so the mode is always one of three
	wire mode_ok = (alloc_r[AL_MODE_LSB +: 2] != 2'h3);

	// Cycles of interest: internal and refresh cycles gated by the config bit
	wire side_cycle = bus_internal | bus_refresh;
	wire cyc_ok = bus_cycle & (~side_cycle | cfg_r[CFG_TRACE_INT]);

	// Resources count only when activated
	wire ra  = cyc_ok & match_a & active_r[ACT_A];
	wire rb  = cyc_ok & match_b & active_r[ACT_B];
	wire rc  = cyc_ok & match_c & active_r[ACT_C];
	wire ren = cyc_ok & match_en & active_r[ACT_EN];
	wire rds = cyc_ok & match_dis & active_r[ACT_DIS];

	// Enable/disable window; enable-only when disable inactive, always open when enable inactive
	logic win_r;
	wire win_open = win_r | ~active_r[ACT_EN];
	wire ed_any   = active_r[ACT_EN] | active_r[ACT_DIS];
	wire qual     = ~ed_any | win_open;

	function automatic logic pick(evt_src_t s, logic a, logic b, logic c);
		unique case (s)
			SRC_A:   pick = a;
			SRC_B:   pick = b;
			SRC_C:   pick = c;
			default: pick = 1'b0;
		endcase
	endfunction

	wire t_start = pick(start_src, ra, rb, rc) & (~alloc_r[AL_ED_START] | qual);
	wire t_end   = pick(end_src, ra, rb, rc) & (~alloc_r[AL_ED_END] | qual);
	wire is_cnt  = mode_ok & (mode == MODE_COUNTER);
	wire p_start = is_cnt ? ren : t_start;
	wire p_end   = is_cnt ? rds : t_end;
	wire p_count = (alloc_r[AL_CNT_SRC] ? rb : ra) & qual;

	// Break/trace: trigger, hardware breakpoint, instruction breakpoints on B
	wire is_bt    = ~mode_ok | (mode == MODE_BRK_TRACE);
	wire hw_brk   = is_bt & pick(brk_src, ra, rb, rc) & qual;
	wire ib_brk   = is_bt & bus_fetch & active_r[ACT_B] & |(ibrk_hit & ibrk_en_r);
	wire trig_now = is_bt & (ra | rc) & qual;
	wire tq       = cyc_ok & (active_r[ACT_A] ? (match_a & qual) : qual);

	// Timer ticks
	logic [4:0] us_cnt_r;
	wire us_tick = (us_cnt_r == 5'(US_CYC - 1));
	logic tick;
	always_comb begin
		unique case (unit)
			UNIT_TSTATE: tick = tgt_clk_tick;
			UNIT_MCYCLE: tick = bus_as;
			UNIT_USEC:   tick = us_tick;
			default:     tick = 1'b0;
		endcase
	end

	logic [TIME_W-1:0] p_result;
	logic              p_done;
	logic              p_over;
	perf_meter #(.W(TIME_W)) u_meter (
		.clk       (core_clk),
		.rst_n     (rs_r),
		.run       (run_r != RUN_BREAK),
		.mode      (mode_ok ? mode : MODE_BRK_TRACE),
		.start_evt (p_start),
		.end_evt   (p_end),
		.count_evt (p_count),
		.tick      (tick),
		.limit     (limit_r),
		.halt_en   (alloc_r[AL_HALT_LIMIT]),
		.result    (p_result),
		.done      (p_done),
		.over      (p_over)
	);

	// Any stop cause; group partners stop us through the chain
	wire local_brk = hw_brk | ib_brk | viol_break | p_over | halt_req;
	wire grp_stop  = group_en & chain_in_r & (run_r != RUN_BREAK);
	wire grp_go    = group_en & chain_in_r & (run_r == RUN_BREAK);
	wire stop_now  = (run_r == RUN_RUNNING) & (local_brk | grp_stop);
	wire start_now = (run_r != RUN_RUNNING) & (go_req | grp_go);
	wire new_analyzer = wr_cfg ? reg_wdata[CFG_ANALYZER] : analyzer;

	// Frequency measure: count target clocks in a fixed gate window
	logic [TIME_W-1:0] gate_r, fcnt_r;
	logic              meas_r;
	// The tick of the closing gate cycle counts too, so the window spans the full gate
	wire [TIME_W-1:0] fcnt_nxt = fcnt_r + {{(TIME_W-1){1'b0}}, tgt_clk_tick};

	always_ff @(posedge core_clk or negedge rs_r) begin
		if (!rs_r) begin
			cfg_r     <= 4'h0;
			alloc_r   <= ALLOC_RST;
			active_r  <= ACTIVE_RST;
			limit_r   <= '0;
			ibrk_en_r <= '0;
		end else begin
			if (wr_cfg)   cfg_r     <= reg_wdata[3:0];
			if (wr_alloc) alloc_r   <= reg_wdata[15:0];
			if (wr_act)   active_r  <= reg_wdata[NUM_ACT-1:0];
			if (wr_lim)   limit_r   <= reg_wdata[TIME_W-1:0];
			if (wr_ibrk)  ibrk_en_r <= reg_wdata[NUM_IBRK-1:0];
		end
	end

	always_ff @(posedge core_clk or negedge rs_r) begin
		if (!rs_r) begin
			win_r    <= 1'b0;
			us_cnt_r <= 5'h00;
			meas_r   <= 1'b1;
			gate_r   <= '0;
			fcnt_r   <= '0;
			freq_r   <= '0;
			chain_in_r <= 1'b0;
		end else begin
			chain_in_r <= chain_in;
			if (ren) win_r <= 1'b1;
			else if (rds) win_r <= 1'b0;
			us_cnt_r <= us_tick ? 5'h00 : us_cnt_r + 5'h01;
			if (meas_req) begin
				meas_r <= 1'b1;
				gate_r <= '0;
				fcnt_r <= '0;
			end else if (meas_r) begin
				gate_r <= gate_r + 1'b1;
				fcnt_r <= fcnt_nxt;
				if (gate_r == TIME_W'(GATE_CYCLES - 1)) begin
					freq_r <= fcnt_nxt;
					meas_r <= 1'b0;
				end
			end
		end
	end

	// Run state and outputs
	always_ff @(posedge core_clk or negedge rs_r) begin
		if (!rs_r) begin
			run_r         <= RUN_BREAK;
			cpu_halt      <= 1'b1;
			trace_attach  <= 1'b0;
			chain_out     <= 1'b0;
			trace_wr      <= 1'b0;
			trace_trigger <= 1'b0;
			time_wr       <= 1'b0;
			time_data     <= '0;
			regs_visible  <= 1'b1;
		end else begin
			if (start_now) begin
				run_r <= RUN_RUNNING;
				cpu_halt <= 1'b0;
				trace_attach <= 1'b1;
			end else if (stop_now) begin
				run_r <= analyzer ? RUN_PSEUDO : RUN_BREAK;
				cpu_halt <= ~analyzer;
				trace_attach <= 1'b0;
			end else if (run_r == RUN_PSEUDO && !new_analyzer) begin
				run_r <= RUN_BREAK;
				cpu_halt <= 1'b1;
			end
			// Pulse the chain on our own start or stop so partners follow
			chain_out <= group_en & ((go_req & (run_r != RUN_RUNNING)) |
				((run_r == RUN_RUNNING) & local_brk));
			trace_wr <= trace_attach & tq & ~(mode_ok & (mode == MODE_TIMER) &
				alloc_r[AL_REC_TIME]);
			trace_trigger <= trace_attach & trig_now;
			time_wr   <= trace_attach & p_done & alloc_r[AL_REC_TIME];
			time_data <= p_result;
			regs_visible <= ~(new_analyzer & ~start_now & (run_r != RUN_RUNNING | stop_now)) &
				~((run_r == RUN_RUNNING) & ~stop_now) & ~start_now;
		end
	end

	// Read mux
	logic [DATA_W-1:0] rd_mux;
	always_comb begin
		unique case (reg_addr)
			REG_CONFIG:   rd_mux = {28'h0000000, cfg_r};
			REG_STATUS:   rd_mux = {29'h00000000, meas_r, run_r};
			REG_ALLOC:    rd_mux = {16'h0000, alloc_r};
			REG_ACTIVE:   rd_mux = {27'h0000000, active_r};
			REG_LIMIT:    rd_mux = limit_r;
			REG_RESULT:   rd_mux = p_result;
			REG_CLK_FREQ: rd_mux = freq_r;
			REG_IBRK_EN:  rd_mux = {16'h0000, ibrk_en_r};
			default:      rd_mux = 32'h00000000;
		endcase
	end

	always_ff @(posedge core_clk or negedge rs_r) begin
		if (!rs_r) reg_rdata <= '0;
		else reg_rdata <= reg_rd ? rd_mux : 32'h00000000;
	end
endmodule

/* dv/trace_break_chk.sv */
// Port assertions of the trace and break control block
`timescale 1ns/1ps
module trace_break_chk
	import trace_ctl_pkg::*;
(
	input wire logic              core_clk,
	input wire logic              rst_n,
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic [DATA_W-1:0] reg_wdata,
	input wire logic              reg_wr,
	input wire logic              reg_rd,
	input wire logic [DATA_W-1:0] reg_rdata,
	input wire logic              bus_cycle,
	input wire logic              bus_internal,
	input wire logic              bus_refresh,
	input wire logic              viol_break,
	input wire logic              chain_out,
	input wire logic              cpu_halt,
	input wire logic              trace_attach,
	input wire logic              trace_wr,
	input wire logic              regs_visible
);
	logic cfg_wr;
	logic tint_r;
	logic grp_r;
	logic ana_r;
	logic pseudo;
	assign cfg_wr = reg_wr && reg_addr == REG_CONFIG;
	assign pseudo = ana_r && !cpu_halt && !trace_attach;
	// Shadow of the configuration bits, so rules can be judged from the ports alone
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			tint_r <= 1'b0;
			grp_r <= 1'b0;
			ana_r <= 1'b0;
		end else if (cfg_wr) begin
			tint_r <= reg_wdata[CFG_TRACE_INT];
			grp_r <= reg_wdata[CFG_GROUP_EN];
			ana_r <= reg_wdata[CFG_ANALYZER];
		end
	end
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	sequence s_go;
		reg_wr && reg_addr == REG_CONTROL && reg_wdata[CTL_GO] && !reg_wdata[CTL_HALT];
	endsequence
	sequence s_brk;
		viol_break && trace_attach && !reg_wr;
	endsequence
	a_go_attach: assert property ((cpu_halt and s_go) |=> !cpu_halt && trace_attach)
		else $error("go did not start and attach");
	a_emu_brk_halt: assert property ((!ana_r and s_brk) |=> cpu_halt && !trace_attach)
		else $error("break in emulator mode did not halt");
	a_ana_brk_run: assert property ((ana_r and s_brk) |=> !cpu_halt && !trace_attach)
		else $error("break in analyzer mode halted or kept trace");
	a_back_to_emu: assert property (pseudo && cfg_wr && !reg_wdata[CFG_ANALYZER] |=> cpu_halt)
		else $error("leaving analyzer when stopped did not halt");
	a_regs_hidden: assert property (pseudo [*2] |-> !regs_visible)
		else $error("registers visible in pseudo halt");
	a_rd_idle_zero: assert property (!$past(reg_rd) |-> reg_rdata == '0)
		else $error("read data not zero outside read answer");
	a_chain_quiet: assert property (!grp_r [*3] |-> !chain_out)
		else $error("chain pulse without group enable");
	a_ign_cycles: assert property (bus_cycle && (bus_internal || bus_refresh) && !tint_r
		&& !cfg_wr |=> !trace_wr)
		else $error("internal or refresh cycle traced while ignored");
	a_trace_cause: assert property (trace_wr |-> $past(bus_cycle))
		else $error("trace record without a bus cycle");
endmodule

bind trace_break_ctl trace_break_chk u_chk (
	.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .bus_cycle(bus_cycle),
	.bus_internal(bus_internal), .bus_refresh(bus_refresh), .viol_break(viol_break),
	.chain_out(chain_out), .cpu_halt(cpu_halt), .trace_attach(trace_attach),
	.trace_wr(trace_wr), .regs_visible(regs_visible)
);

/* dv/target_model.sv */
// Model of the target CPU bus and of the peer unit on the group chain
`timescale 1ns/1ps
module target_model (
	input  wire logic core_clk,
	input  wire logic rst_n,
	input  wire logic cpu_halt,
	input  wire logic act,
	input  wire logic tick_en,
	input  wire logic peer_req,
	output logic      bus_cycle,
	output logic      bus_internal,
	output logic      bus_refresh,
	output logic      bus_fetch,
	output logic      bus_as,
	output logic      tgt_clk_tick,
	output logic      chain_in
);
	logic [1:0] ph_r;
	logic       run;
	assign run = act && !cpu_halt;
	// Qualifiers keep cycling while idle, so a stale level never passes for a cycle kind
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			ph_r <= 2'h0;
			bus_cycle <= 1'b0;
			bus_internal <= 1'b0;
			bus_refresh <= 1'b0;
			bus_fetch <= 1'b0;
			bus_as <= 1'b0;
			tgt_clk_tick <= 1'b0;
			chain_in <= 1'b0;
		end else begin
			ph_r <= ph_r + 2'h1;
			bus_cycle <= run;
			bus_internal <= ph_r == 2'h1;
			bus_refresh <= ph_r == 2'h2;
			bus_fetch <= ph_r == 2'h0;
			bus_as <= run && ph_r == 2'h0;
			tgt_clk_tick <= tick_en && !tgt_clk_tick;
			chain_in <= peer_req;
		end
	end
endmodule

/* dv/testbench.sv */
// Self-checking bench of the trace and break control block
`timescale 1ns/1ps
module testbench
	import trace_ctl_pkg::*;
;
	localparam int GATE = 20;
	logic              core_clk = 1'b0;
	logic              rst_n = 1'b0;
	logic [ADDR_W-1:0] reg_addr = '0;
	logic [DATA_W-1:0] reg_wdata = '0;
	logic              reg_wr = 1'b0;
	logic              reg_rd = 1'b0;
	logic              act = 1'b0;
	logic              tick_en = 1'b1;
	logic [6:0]        drv = 7'h00;
	logic [NUM_IBRK-1:0] ibrk = '0;
	logic [DATA_W-1:0] reg_rdata;
	logic [TIME_W-1:0] time_data;
	logic [TIME_W-1:0] last_t;
	logic bus_cycle, bus_internal, bus_refresh, bus_fetch, bus_as, tgt_clk_tick, chain_in;
	logic chain_out, cpu_halt, trace_attach, trace_wr, trace_trigger, time_wr, regs_visible;
	int n_errors = 0, checked = 0, n_all = 0, n_norm = 0, n_tr = 0, n_time = 0, n_chain = 0;
	int n_trig = 0;
	int a0, b0;

	always #25 core_clk = ~core_clk;

	trace_break_ctl #(.GATE_CYCLES(GATE)) u_dut (
		.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .bus_cycle(bus_cycle),
		.bus_internal(bus_internal), .bus_refresh(bus_refresh), .bus_fetch(bus_fetch),
		.bus_as(bus_as), .tgt_clk_tick(tgt_clk_tick), .match_a(drv[0]), .match_b(drv[1]),
		.match_c(drv[2]), .match_en(drv[3]), .match_dis(drv[4]), .ibrk_hit(ibrk),
		.viol_break(drv[5]), .chain_in(chain_in), .chain_out(chain_out), .cpu_halt(cpu_halt),
		.trace_attach(trace_attach), .trace_wr(trace_wr), .trace_trigger(trace_trigger),
		.time_wr(time_wr), .time_data(time_data), .regs_visible(regs_visible));

	target_model u_tgt (
		.core_clk(core_clk), .rst_n(rst_n), .cpu_halt(cpu_halt), .act(act),
		.tick_en(tick_en), .peer_req(drv[6]), .bus_cycle(bus_cycle),
		.bus_internal(bus_internal), .bus_refresh(bus_refresh), .bus_fetch(bus_fetch),
		.bus_as(bus_as), .tgt_clk_tick(tgt_clk_tick), .chain_in(chain_in));

	// Values seen here are those of the cycle that just ended
	always @(posedge core_clk) begin
		n_all += (bus_cycle === 1'b1);
		n_norm += (bus_cycle === 1'b1 && bus_internal === 1'b0 && bus_refresh === 1'b0);
		n_tr += (trace_wr === 1'b1);
		n_chain += (chain_out === 1'b1);
		n_trig += (trace_trigger === 1'b1);
		if (time_wr === 1'b1) begin
			n_time++;
			last_t = time_data;
		end
	end

	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
		@(posedge core_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= v;
		@(posedge core_clk);
		reg_wr <= 1'b0;
		#1;
	endtask
	task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
		checked++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic rchk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
		@(posedge core_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1;
		chk(reg_rdata, exp);
	endtask
	task automatic hs(input logic h, input logic at);
		chk({30'h0, cpu_halt, trace_attach}, {30'h0, h, at});
	endtask
	// One-cycle pulse on peer request, violation and the five matchers
	task automatic pls(input logic [6:0] v);
		@(posedge core_clk);
		drv <= v;
		@(posedge core_clk);
		drv <= 7'h00;
		#1;
	endtask
	task automatic complete_run;
		$display("Comparisons %0d, mismatches %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	initial begin
		cyc(20000);
		n_errors++;
		complete_run();
	end

	initial begin
		cyc(3);
		rst_n <= 1'b1;
		cyc(30);
		hs(1'b1, 1'b0);
		chk(32'(regs_visible), 32'h1);
		rchk(REG_CLK_FREQ, 32'(GATE / 2));
		rchk(REG_STATUS, 32'h0);
		rchk(REG_ALLOC, 32'h0);
		rchk(REG_ACTIVE, 32'h0);
		rchk(4'hF, 32'h0);
		wr(REG_IBRK_EN, 32'h0000FFFF);
		rchk(REG_IBRK_EN, 32'h0000FFFF);
		wr(REG_CONTROL, 32'h1);
		hs(1'b0, 1'b1);
		rchk(REG_STATUS, 32'h1);
		pls(7'h20);
		hs(1'b1, 1'b0);
		chk(32'(regs_visible), 32'h1);
		rchk(REG_STATUS, 32'h0);
		wr(REG_CONTROL, 32'h1);
		wr(REG_CONTROL, 32'h2);
		hs(1'b1, 1'b0);
		wr(REG_CONFIG, 32'h4);
		wr(REG_CONTROL, 32'h1);
		hs(1'b0, 1'b1);
		pls(7'h20);
		cyc(1);
		hs(1'b0, 1'b0);
		chk(32'(regs_visible), 32'h0);
		rchk(REG_STATUS, 32'h2);
		wr(REG_CONFIG, 32'h0);
		hs(1'b1, 1'b0);
		wr(REG_CONFIG, 32'h2);
		a0 = n_chain;
		pls(7'h40);
		cyc(3);
		hs(1'b0, 1'b1);
		pls(7'h40);
		cyc(3);
		hs(1'b1, 1'b0);
		wr(REG_CONTROL, 32'h1);
		wr(REG_CONTROL, 32'h2);
		cyc(2);
		chk(32'(n_chain - a0), 32'h2);
		wr(REG_CONFIG, 32'h0);
		pls(7'h40);
		cyc(3);
		hs(1'b1, 1'b0);
		for (int t = 0; t < 2; t++) begin
			wr(REG_CONFIG, 32'(t));
			wr(REG_CONTROL, 32'h1);
			a0 = n_tr;
			b0 = t ? n_all : n_norm;
			act <= 1'b1;
			cyc(40);
			act <= 1'b0;
			cyc(3);
			chk(32'(n_tr - a0), 32'((t ? n_all : n_norm) - b0));
			wr(REG_CONTROL, 32'h2);
		end
		wr(REG_LIMIT, 32'h7);
		// First pass has no activated resource, then machine cycles, then T states
		for (int u = 0; u < 3; u++) begin
			wr(REG_ALLOC, u == 2 ? 32'h1812 : 32'h1A12);
			wr(REG_ACTIVE, u ? 32'h3 : 32'h0);
			wr(REG_CONTROL, 32'h1);
			act <= 1'b1;
			a0 = n_time;
			cyc(4);
			pls(7'h01);
			cyc(18);
			pls(7'h02);
			cyc(3);
			chk(32'(n_time - a0), u ? 32'h1 : 32'h0);
			chk(u ? last_t : 32'h0, u == 2 ? 32'hA : u ? 32'h5 : 32'h0);
			hs(u == 2, u != 2);
			act <= 1'b0;
			wr(REG_CONTROL, 32'h2);
		end
		wr(REG_ALLOC, 32'h1);
		wr(REG_ACTIVE, 32'h19);
		act <= 1'b1;
		wr(REG_CONTROL, 32'h1);
		pls(7'h01);
		pls(7'h08);
		for (int i = 0; i < 3; i++) begin
			pls(7'h01);
		end
		pls(7'h10);
		pls(7'h01);
		cyc(3);
		rchk(REG_RESULT, 32'h3);
		wr(REG_CONTROL, 32'h2);
		rchk(REG_ALLOC, 32'h1);
		// Default allocation: A triggers the trace and is the hardware breakpoint
		wr(REG_ALLOC, 32'h0);
		wr(REG_ACTIVE, 32'h1);
		wr(REG_CONTROL, 32'h1);
		a0 = n_trig;
		pls(7'h01);
		cyc(1);
		chk(32'(n_trig - a0), 32'h1);
		hs(1'b1, 1'b0);
		// Instruction breakpoint on B: four cycles of hit cover one fetch
		wr(REG_ACTIVE, 32'h2);
		wr(REG_CONTROL, 32'h1);
		@(posedge core_clk);
		ibrk <= 16'h0001;
		repeat (4) @(posedge core_clk);
		ibrk <= 16'h0000;
		#1;
		hs(1'b1, 1'b0);
		complete_run();
	end
endmodule
